// >>> bitop_decode.sv
// Instruction word decoder for the branch and bit-operation slice.
`include "bitop_map.svh"
module bitop_decode (
    input wire logic [15:0] instr_i,
    output bitop_pkg::op_type op_o
);
    always_comb
    begin
        if (instr_i[15:8] == `OPC_BZC)
            op_o = bitop_pkg::OP_BZC;
        else if (instr_i[15:11] == `OPC_JMP)
            op_o = bitop_pkg::OP_JMP;
        else if (instr_i[15:12] == `OPC_BSET)
            op_o = bitop_pkg::OP_BSET;
        else if (instr_i[15:12] == `OPC_TSC)
            op_o = bitop_pkg::OP_TSC;
        else if (instr_i[15:12] == `OPC_TSS)
            op_o = bitop_pkg::OP_TSS;
        else
            op_o = bitop_pkg::OP_NONE;
    end
endmodule // bitop_decode

// >>> bitop_map.svh
// Opcode patterns, field positions and cycle counts for the branch and bit-operation slice.
`ifndef BITOP_MAP_SVH
`define BITOP_MAP_SVH
`define OPC_BZC 8'hE1
`define OPC_JMP 5'h1A
`define OPC_BSET 4'h8
`define OPC_TSC 4'hB
`define OPC_TSS 4'hA
`define BIT_IDX_MSB 11
`define BIT_IDX_LSB 9
`define BANK_SEL_BIT 8
`define PHASE_COUNT 2'h3
`define PC_STEP 21'h00_0002
`define PC_RESET 21'h00_0000
`endif

// >>> bitop_pkg.sv
// Types shared by the branch and bit-operation slice.
package bitop_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_BZC = 3'b001,
        OP_JMP = 3'b010,
        OP_BSET = 3'b011,
        OP_TSC = 3'b100,
        OP_TSS = 3'b101
    } op_type;
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
    } data_addr_type;
endpackage

// >>> branch_and_bit_op_exec.sv
// Four-phase executor for conditional and relative branches, bit set and bit test with skip.
`include "bitop_map.svh"
module branch_and_bit_op_exec (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [15:0] instr_i,
    input wire logic next_two_word_i,
    input wire logic zero_flag_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic [7:0] rd_data_i,
    output logic [20:0] pc_o,
    output bitop_pkg::data_addr_type rd_addr_o,
    output bitop_pkg::data_addr_type wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_en_o,
    output logic flush_o,
    output logic [1:0] phase_o
);
    // The flags are only an input; nothing here writes status, so flags stay untouched.
    bitop_pkg::op_type op;
    logic [1:0] phase_reg, phase_next;
    logic [20:0] pc_reg, pc_next;
    logic [1:0] idle_reg, idle_next;
    logic [15:0] ir_reg, ir_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wen_reg, wen_next;
    bitop_pkg::data_addr_type waddr_reg, waddr_next;
    logic bit_val;
    bitop_pkg::data_addr_type ea;
    // Marks an idle cycle that follows a taken branch rather than a skip.
    logic jump_reg, jump_next;

    bitop_decode u_dec (
        .instr_i(ir_reg),
        .op_o(op)
    );

    function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [20:0] off);
        rel_target = pc + (off << 1);
    endfunction

    function automatic bitop_pkg::data_addr_type eff_addr(input logic [15:0] ir,
                                                         input logic [3:0] bank);
        eff_addr.addr = ir[7:0];
        eff_addr.bank = ir[`BANK_SEL_BIT] ? bank : 4'h0;
    endfunction

    always_comb
    begin
        ea = eff_addr(ir_reg, bank_select_register_i);
        bit_val = rd_data_i[ir_reg[`BIT_IDX_MSB:`BIT_IDX_LSB]];
    end

    // Phase 0 latches the word and bumps the PC, so offsets see PC already advanced.
    always_comb
    begin
        phase_next = phase_reg + 2'h1;
        pc_next = pc_reg;
        idle_next = idle_reg;
        ir_next = ir_reg;
        wdata_next = wdata_reg;
        wen_next = 1'b0;
        waddr_next = waddr_reg;
        jump_next = jump_reg;
        if (phase_reg == 2'h0)
        begin
            if (idle_reg != 2'h0)
            begin
                idle_next = idle_reg - 2'h1;
                ir_next = 16'hFFFF;
            end
            else
            begin
                ir_next = instr_i;
            end
            // A skip steps past the dropped word, but after a branch the PC already holds
            // the target, so that idle cycle must leave it for the next fetch.
            if (!jump_reg)
            begin
                pc_next = pc_reg + `PC_STEP;
            end
            jump_next = 1'b0;
        end
        else if (phase_reg == `PHASE_COUNT && idle_reg == 2'h0 && ir_reg != 16'hFFFF)
        begin
            case (op)
                bitop_pkg::OP_BZC:
                begin
                    if (!zero_flag_i)
                    begin
                        pc_next = rel_target(pc_reg, {{13{ir_reg[7]}}, ir_reg[7:0]});
                        idle_next = 2'h1;
                        jump_next = 1'b1;
                    end
                end
                bitop_pkg::OP_JMP:
                begin
                    pc_next = rel_target(pc_reg, {{10{ir_reg[10]}}, ir_reg[10:0]});
                    idle_next = 2'h1;
                    jump_next = 1'b1;
                end
                bitop_pkg::OP_BSET:
                begin
                    wdata_next = rd_data_i | (8'h01 << ir_reg[`BIT_IDX_MSB:`BIT_IDX_LSB]);
                    waddr_next = ea;
                    wen_next = 1'b1;
                end
                bitop_pkg::OP_TSC, bitop_pkg::OP_TSS:
                begin
                    if (bit_val == (op == bitop_pkg::OP_TSS))
                        idle_next = next_two_word_i ? 2'h2 : 2'h1;
                end
                default:
                begin
                    idle_next = idle_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            phase_reg <= 2'h0;
            pc_reg <= `PC_RESET;
            idle_reg <= 2'h0;
            ir_reg <= 16'hFFFF;
            wdata_reg <= 8'h00;
            wen_reg <= 1'b0;
            waddr_reg <= '0;
            jump_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            pc_reg <= pc_next;
            idle_reg <= idle_next;
            ir_reg <= ir_next;
            wdata_reg <= wdata_next;
            wen_reg <= wen_next;
            waddr_reg <= waddr_next;
            jump_reg <= jump_next;
        end
    end

    assign pc_o = pc_reg;
    assign rd_addr_o = ea;
    assign wr_addr_o = waddr_reg;
    assign wr_data_o = wdata_reg;
    assign wr_en_o = wen_reg;
    assign flush_o = (idle_reg != 2'h0);
    assign phase_o = phase_reg;

    // Checks on the executed behaviour.
    jump_target_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && idle_reg == 2'h0 && ir_reg != 16'hFFFF
         && op == bitop_pkg::OP_JMP)
        |=> pc_reg == $past(pc_reg) + {{9{$past(ir_reg[10])}}, $past(ir_reg[10:0]), 1'b0})
        else $error("Relative jump target wrong.");
    jump_idle_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_JMP) |=> ##1 ir_reg == 16'hFFFF)
        else $error("Jump did not insert idle cycle.");
    bzc_untaken_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_BZC && zero_flag_i) |=> $stable(pc_reg) && idle_reg == 2'h0)
        else $error("Untaken branch moved PC.");
    bzc_taken_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_BZC && !zero_flag_i) |=> idle_reg == 2'h1)
        else $error("Taken branch did not flush.");
    bit_set_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wen_reg |-> wdata_reg[$past(ir_reg[11:9])] == 1'b1)
        else $error("Set bit not written as one.");
    bank_pick_a: assert property (@(posedge clock_i) disable iff (reset_i)
        !ir_reg[8] |-> rd_addr_o.bank == 4'h0)
        else $error("Access bank not used.");
    skip_two_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && (op == bitop_pkg::OP_TSC || op == bitop_pkg::OP_TSS)
         && bit_val == (op == bitop_pkg::OP_TSS) && next_two_word_i) |=> idle_reg == 2'h2)
        else $error("Two-word skip wrong length.");
    noskip_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_TSC && bit_val) |=> idle_reg == 2'h0)
        else $error("Skip taken on set bit.");
    jump_cov: cover property (@(posedge clock_i) phase_reg == 2'h3 && op == bitop_pkg::OP_JMP);
    set_cov: cover property (@(posedge clock_i) wen_reg);
    skip_cov: cover property (@(posedge clock_i) idle_reg == 2'h2);
    untaken_cov: cover property (@(posedge clock_i) phase_reg == 2'h3 && op == bitop_pkg::OP_BZC
        && zero_flag_i);
    skip_one_cov: cover property (@(posedge clock_i) idle_reg == 2'h1 && !jump_reg);
    target_kept_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h0 && jump_reg) |=> $stable(pc_reg) && ir_reg == 16'hFFFF)
        else $error("Idle cycle moved branch target.");
    bank_bsr_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (ir_reg[8] && ir_reg != 16'hFFFF) |-> rd_addr_o.bank == bank_select_register_i)
        else $error("Bank select register not used.");
    skip_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_TSC && !bit_val) |=> idle_reg != 2'h0)
        else $error("Clear bit did not skip.");
    skip_set_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (phase_reg == 2'h3 && ir_reg != 16'hFFFF && idle_reg == 2'h0
         && op == bitop_pkg::OP_TSS && bit_val) |=> idle_reg != 2'h0)
        else $error("Set bit did not skip.");
    set_others_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wen_reg |-> (wdata_reg | (8'h01 << $past(ir_reg[11:9])))
            == ($past(rd_data_i) | (8'h01 << $past(ir_reg[11:9]))))
        else $error("Set changed other bits.");
endmodule // branch_and_bit_op_exec

// >>> fetch_data_model.sv
// Program memory and banked data memory model for the branch and bit-operation slice.
module fetch_data_model (
    input wire logic clock_i,
    input wire logic [20:0] pc_i,
    input bitop_pkg::data_addr_type rd_addr_i,
    input bitop_pkg::data_addr_type wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    output logic [15:0] instr_o,
    output logic [7:0] rd_data_o,
    output logic next_two_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] prog [0:15];
    logic two_word [0:15];
    logic [7:0] data [0:4095];
    // The program is short, so only the low word index bits select a program word.
    assign instr_o = prog[pc_i[4:1]];
    assign next_two_word_o = two_word[pc_i[4:1]];
    assign rd_data_o = data[rd_addr_i];
    always @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            data[wr_addr_i] <= wr_data_i;
        end
    end
endmodule // fetch_data_model

// >>> tb_branch_and_bit_op_exec.sv
// Self-checking testbench for the branch and bit-operation slice.
module tb_branch_and_bit_op_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic zero_flag_i = 1'b0;
    logic [3:0] bank_sel = 4'h3;
    logic [15:0] instr;
    logic [7:0] rd_data;
    logic [7:0] wr_data;
    logic two_word;
    logic wr_en;
    logic flush;
    logic [20:0] pc;
    logic [1:0] phase;
    bitop_pkg::data_addr_type rd_addr;
    bitop_pkg::data_addr_type wr_addr;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_fetch = 0;
    logic [20:0] fetch_pc [0:31];
    int fetch_at [0:31];
    always #25 clock_i = ~clock_i;
    branch_and_bit_op_exec DUT (.clock_i(clock_i), .reset_i(reset_i), .instr_i(instr),
        .next_two_word_i(two_word), .zero_flag_i(zero_flag_i), .bank_select_register_i(bank_sel),
        .rd_data_i(rd_data), .pc_o(pc), .rd_addr_o(rd_addr), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_en_o(wr_en), .flush_o(flush), .phase_o(phase));
    fetch_data_model mem (.clock_i(clock_i), .pc_i(pc), .rd_addr_i(rd_addr),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_en_i(wr_en), .instr_o(instr),
        .rd_data_o(rd_data), .next_two_word_o(two_word));
    // Fetches are logged with pre-edge values, so order against the design's updates is moot.
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            fail_count++;
            print_verdict();
        end
        else if (!reset_i && phase === 2'h0 && flush === 1'b0 && n_fetch < 32)
        begin
            fetch_pc[n_fetch] = pc;
            fetch_at[n_fetch] = cycles;
            n_fetch++;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Instruction cycles are counted from the first fetch, four clocks each.
    task automatic check_fetch(input int k, input logic [20:0] addr, input int icyc);
        check({11'h000, fetch_pc[k]}, {11'h000, addr});
        check((fetch_at[k] - fetch_at[0]) / 4, icyc);
    endtask
    task automatic branch_zero_clear;
        check_fetch(1, 21'h00_0006, 2);
        check_fetch(6, 21'h00_0012, 8);
    endtask
    task automatic bit_set;
        check(mem.data[12'h010], 8'h2A);
        check(mem.data[12'h320], 8'hC5);
        check(mem.data[12'h310], 8'h00);
    endtask
    task automatic test_skip;
        check_fetch(3, 21'h00_000A, 4);
        check_fetch(5, 21'h00_0010, 7);
        check(mem.data[12'h011], 8'h55);
        check_fetch(7, 21'h00_0018, 11);
    endtask
    task automatic jump_always;
        check_fetch(8, 21'h00_0018, 13);
        check_fetch(9, 21'h00_0018, 15);
    endtask
    task automatic print_verdict;
        $display("Counts: %0d mismatches in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        mem.prog = '{16'hE102, 16'hFFFF, 16'hFFFF, 16'h8A10, 16'h8120, 16'hBA10, 16'hAA10,
            16'h8A11, 16'hE17F, 16'hB320, 16'hFFFF, 16'hFFFF, 16'hD7FF, 16'hFFFF,
            16'hFFFF, 16'hFFFF};
        foreach (mem.two_word[i]) mem.two_word[i] = (i == 10);
        mem.data[12'h010] = 8'h0A;
        mem.data[12'h011] = 8'h55;
        mem.data[12'h320] = 8'hC4;
        mem.data[12'h310] = 8'h00;
        repeat (16) @(posedge clock_i);
        #1 reset_i = 1'b0;
        wait (n_fetch == 5);
        @(posedge clock_i);
        #1 zero_flag_i = 1'b1;
        wait (n_fetch == 10);
        branch_zero_clear();
        bit_set();
        test_skip();
        jump_always();
        print_verdict();
    end
endmodule // tb_branch_and_bit_op_exec
